/* uhfp_host_regs.v */
// Purpose: frame index, configure flag and port status/control registers
// Assumes: processor writes whole words on a simple synchronous strobe port
// Notes: port state inputs come from the port logic outside this block
`timescale 1ns/1ps
`include "uhfp_consts.vh"

module uhfp_host_regs (
  input wire sys_clk,
  input wire rst_n,
  input wire hc_reset,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [3:0] reg_be,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  input wire run_stop_bit,
  input wire [1:0] list_size_field,
  input wire port_power_control,
  input wire connect_present_in,
  input wire connect_event,
  input wire [1:0] line_state_in,
  input wire port_reset_in,
  input wire resume_detect,
  output reg [13:0] sof_frame_number,
  output reg [9:0] list_entry,
  output reg schedule_active,
  output reg uframe_end,
  output reg default_routing,
  output reg port_owner_bit,
  output reg port_power_bit,
  output reg port_enabled_bit,
  output reg port_suspend_bit,
  output reg force_resume_bit,
  output reg [3:0] port_test_select
);

  reg [`UHFP_FRIDX_MSB:0] microframe_counter;
  reg configured_bit;
  reg cf_prev;
  reg owner;
  reg power;
  reg enabled;
  reg suspend;
  reg resume;
  reg change;
  reg [3:0] test_sel;
  reg [31:0] next_rdata;
  wire tick;
  wire [9:0] entry;
  wire full_word;
  wire wr_fidx;
  wire wr_cf;
  wire wr_port;
  wire port_writable;
  wire [31:0] port_view;

  // ------------------------------
  // write decode
  // ------------------------------
  // only whole-word writes take effect on the frame index
  assign full_word = (reg_be == 4'hf);
  assign wr_fidx = reg_wr && full_word && (reg_addr == `UHFP_ADDR_FRAME_INDEX);
  assign wr_cf = reg_wr && (reg_addr == `UHFP_ADDR_CONFIG_FLAG) && reg_be[0];
  assign wr_port = reg_wr && (reg_addr == `UHFP_ADDR_PORT_SC);
  assign port_writable = power || !port_power_control;

  // ------------------------------
  // microframe timing and index
  // ------------------------------
  // timer runs only with run/stop set
  uhfp_uframe_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(run_stop_bit),
    .tick(tick)
  );

  uhfp_list_index u_index (
    .frame_idx(microframe_counter),
    .list_size_field(list_size_field),
    .entry(entry)
  );

  // frame index counter
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      microframe_counter <= {`UHFP_FRIDX_W{1'b0}};
    end else if (hc_reset) begin
      microframe_counter <= {`UHFP_FRIDX_W{1'b0}};
    end else if (wr_fidx) begin
      microframe_counter <= reg_wdata[`UHFP_FRIDX_MSB:0];
    end else if (tick) begin
      if (microframe_counter == `UHFP_FRIDX_MAX) begin
        microframe_counter <= {`UHFP_FRIDX_W{1'b0}};
      end else begin
        microframe_counter <= microframe_counter + `UHFP_FRIDX_ONE;
      end
    end
  end

  // ------------------------------
  // configure flag
  // ------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      configured_bit <= 1'b0;
      cf_prev <= 1'b0;
    end else begin
      cf_prev <= configured_bit;
      if (hc_reset) begin
        configured_bit <= 1'b0;
      end else if (wr_cf) begin
        configured_bit <= reg_wdata[`UHFP_CF_BIT];
      end
    end
  end

  // ------------------------------
  // port status and control
  // ------------------------------
  // reset on power-on or controller reset only
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      owner <= 1'b1;
      power <= 1'b0;
      enabled <= 1'b0;
      suspend <= 1'b0;
      resume <= 1'b0;
      change <= 1'b0;
      test_sel <= 4'h0;
    end else if (hc_reset) begin
      owner <= 1'b1;
      power <= 1'b0;
      enabled <= 1'b0;
      suspend <= 1'b0;
      resume <= 1'b0;
      change <= 1'b0;
      test_sel <= 4'h0;
    end else begin
      if (!configured_bit) begin
        owner <= 1'b1;
      end else if (!cf_prev) begin
        owner <= 1'b0;
      end else if (wr_port) begin
        owner <= reg_wdata[`UHFP_PO_BIT];
      end
      if (wr_port) begin
        power <= reg_wdata[`UHFP_PP_BIT];
      end
      // state bits move only when powered or when port_power_control is low
      if (wr_port && port_writable) begin
        enabled <= reg_wdata[`UHFP_PED_BIT];
        suspend <= reg_wdata[`UHFP_PORT_SUSPEND_BIT_BIT];
        test_sel <= reg_wdata[`UHFP_PTC_MSB:`UHFP_PTC_LSB];
      end
      // resume detect sets, write may also drive it
      if (resume_detect) begin
        resume <= 1'b1;
      end else if (wr_port && port_writable) begin
        resume <= reg_wdata[`UHFP_FPR_BIT];
      end
      // change flag: event wins over clear
      if (connect_event) begin
        change <= 1'b1;
      end else if (wr_port && port_writable && reg_wdata[`UHFP_CSC_BIT]) begin
        change <= 1'b0;
      end
    end
  end

  assign port_view = {12'h000, test_sel, 2'b00, owner, power, line_state_in, 1'b0,
                      port_reset_in & power, suspend & power, resume & power, 3'b000,
                      enabled & power, change & power, connect_present_in & power};

  // ------------------------------
  // read path
  // ------------------------------
  // reserved bits read zero
  always @* begin
    case (reg_addr)
      `UHFP_ADDR_FRAME_INDEX: next_rdata = {18'h0_0000, microframe_counter};
      `UHFP_ADDR_CONFIG_FLAG: next_rdata = {31'h0000_0000, configured_bit};
      `UHFP_ADDR_PORT_SC: next_rdata = port_view;
      default: next_rdata = `UHFP_ZERO32;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `UHFP_ZERO32;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ------------------------------
  // registered outputs
  // ------------------------------
  // routing from configured bit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sof_frame_number <= 14'h0000;
      list_entry <= 10'h000;
      schedule_active <= 1'b0;
      uframe_end <= 1'b0;
      default_routing <= 1'b0;
      port_owner_bit <= 1'b1;
      port_power_bit <= 1'b0;
      port_enabled_bit <= 1'b0;
      port_suspend_bit <= 1'b0;
      force_resume_bit <= 1'b0;
      port_test_select <= 4'h0;
    end else begin
      sof_frame_number <= microframe_counter;
      list_entry <= entry;
      schedule_active <= run_stop_bit;
      uframe_end <= tick;
      default_routing <= configured_bit;
      port_owner_bit <= owner;
      port_power_bit <= power;
      port_enabled_bit <= enabled & power;
      port_suspend_bit <= suspend & power;
      force_resume_bit <= resume & power;
      port_test_select <= test_sel;
    end
  end

endmodule

/* uhfp_consts.vh */
// Purpose: constants for the frame index, configure flag and port register block
// Assumes: 10 MHz system clock, 32-bit register word, byte addresses
// Notes: definitions only
`ifndef UHFP_CONSTS_VH
`define UHFP_CONSTS_VH

// register byte addresses
`define UHFP_ADDR_FRAME_INDEX 8'h2c
`define UHFP_ADDR_CONFIG_FLAG 8'h60
`define UHFP_ADDR_PORT_SC 8'h64

// frame index field
`define UHFP_FRIDX_W 14
`define UHFP_FRIDX_MSB 13
`define UHFP_FRIDX_MAX 14'h3fff
`define UHFP_FRIDX_ONE 14'h0001
`define UHFP_LIST_LSB 3

// list size field codes
`define UHFP_LIST_1024 2'h0
`define UHFP_LIST_512 2'h1
`define UHFP_LIST_256 2'h2

// microframe timing
`define UHFP_UFRAME_NS 125000
`define UHFP_CLK_NS 100
`define UHFP_UFRAME_CYC (`UHFP_UFRAME_NS / `UHFP_CLK_NS)
`define UHFP_TICK_W 11
// last count of a microframe, 1250 cycles minus one
`define UHFP_UFRAME_LAST 11'h4e1

// configure flag field
`define UHFP_CF_BIT 0

// port register fields
`define UHFP_PTC_MSB 19
`define UHFP_PTC_LSB 16
`define UHFP_PIC_MSB 15
`define UHFP_PIC_LSB 14
`define UHFP_PO_BIT 13
`define UHFP_PP_BIT 12
`define UHFP_LS_MSB 11
`define UHFP_LS_LSB 10
`define UHFP_PR_BIT 8
`define UHFP_PORT_SUSPEND_BIT_BIT 7
`define UHFP_FPR_BIT 6
`define UHFP_PED_BIT 2
`define UHFP_CSC_BIT 1
`define UHFP_CCS_BIT 0
`define UHFP_ZERO32 32'h0000_0000

`endif

/* uhfp_uframe_timer.v */
// Purpose: one-cycle tick at the end of each microframe
// Assumes: runs only while the schedule runs
// Notes: restarts from zero whenever stopped
`timescale 1ns/1ps
`include "uhfp_consts.vh"

module uhfp_uframe_timer (
  input wire sys_clk,
  input wire rst_n,
  input wire run,
  output reg tick
);

  localparam [`UHFP_TICK_W-1:0] LAST = `UHFP_UFRAME_LAST;

  reg [`UHFP_TICK_W-1:0] count;

  // ------------------------------
  // microframe counter
  // ------------------------------
  // microframe period tick
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {`UHFP_TICK_W{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      count <= {`UHFP_TICK_W{1'b0}};
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= {`UHFP_TICK_W{1'b0}};
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

/* uhfp_list_index.v */
// Purpose: periodic frame list index from frame index bits n..3
// Assumes: list size code from the command register
// Notes: combinational, reserved codes treated as 1024 entries
`timescale 1ns/1ps
`include "uhfp_consts.vh"

module uhfp_list_index (
  input wire [`UHFP_FRIDX_MSB:0] frame_idx,
  input wire [1:0] list_size_field,
  output reg [9:0] entry
);

  // index from bits n down to 3
  always @* begin
    case (list_size_field)
      `UHFP_LIST_512: entry = {1'b0, frame_idx[11:`UHFP_LIST_LSB]};
      `UHFP_LIST_256: entry = {2'b00, frame_idx[10:`UHFP_LIST_LSB]};
      default: entry = frame_idx[12:`UHFP_LIST_LSB];
    endcase
  end

endmodule

/* uhfp_host_regs_properties.sv */
// Purpose: frame index, routing, list index and port properties of the host register block
// Assumes: one clock, rst_n async low
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "uhfp_consts.vh"
module uhfp_host_regs_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hc_reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic run_stop_bit,
  input wire logic [1:0] list_size_field,
  input wire logic [13:0] sof_frame_number,
  input wire logic [9:0] list_entry,
  input wire logic uframe_end,
  input wire logic default_routing,
  input wire logic port_owner_bit,
  input wire logic port_power_bit,
  input wire logic port_enabled_bit,
  input wire logic port_suspend_bit,
  input wire logic force_resume_bit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // frame counter, owner and port field relations
  a_frame_step: assert property (uframe_end && !reg_wr && !$past(reg_wr)
    |-> ##1 sof_frame_number == $past(sof_frame_number, 2) + 14'h0001) else $error("step");
  a_frame_write: assert property (reg_wr && reg_be == 4'hf
    && reg_addr == `UHFP_ADDR_FRAME_INDEX
    |-> ##2 {18'h0, sof_frame_number} == ($past(reg_wdata, 2) & 32'h0000_3fff))
    else $error("write");
  a_cf_routing: assert property (reg_wr && reg_be[0] && reg_addr == `UHFP_ADDR_CONFIG_FLAG
    |-> ##2 default_routing == $past(reg_wdata[0], 2)) else $error("routing");
  a_owner_forced: assert property (!default_routing && !$past(default_routing)
    |-> port_owner_bit) else $error("owner");
  a_owner_clears: assert property ($rose(default_routing)
    |-> ##[0:1] !port_owner_bit) else $error("owner clear");
  a_power_gate: assert property (!port_power_bit && !$past(port_power_bit)
    |-> !(port_enabled_bit | port_suspend_bit | force_resume_bit)) else $error("gate");
  a_hc_clear: assert property (hc_reset && !run_stop_bit |-> ##2 port_owner_bit
    && !port_power_bit && !port_enabled_bit && sof_frame_number == 14'h0000) else $error("hc");
  a_list_index: assert property ($stable(list_size_field) |-> list_entry ==
    (list_size_field == 2'h1 ? {1'h0, sof_frame_number[11:3]} :
    list_size_field == 2'h2 ? {2'h0, sof_frame_number[10:3]} : sof_frame_number[12:3]))
    else $error("index");
  c_tick: cover property (uframe_end);
  c_cf_rise: cover property ($rose(default_routing));
  c_power_on: cover property ($rose(port_power_bit));
endmodule

/* uhfp_usb_device.sv */
// Purpose: peripheral model on the downstream port
// Assumes: plug and wake commanded by the bench
// Notes: detached lines sit at zero through pull-downs
`timescale 1ns/1ps
module uhfp_usb_device (
  input wire logic sys_clk,
  input wire logic plug,
  input wire logic wake,
  output logic connect_present_in,
  output logic connect_event,
  output logic [1:0] line_state_in,
  output logic port_reset_in,
  output logic resume_detect
);
  initial {connect_present_in, connect_event, line_state_in, resume_detect} = 5'h00;
  // attach pulse, idle lines, resume signalling
  always @(posedge sys_clk) begin
    connect_event <= plug ^ connect_present_in;
    connect_present_in <= plug;
    line_state_in <= plug ? 2'h2 : 2'h0;
    resume_detect <= wake & plug;
  end
  assign port_reset_in = 1'b0;
endmodule

/* tb_uhfp_host_regs.sv */
// Purpose: self-checking bench for the host register block
// Assumes: 10 MHz clock, device model on the port
// Notes: full 1250-cycle microframes
`timescale 1ns/1ps
`include "uhfp_consts.vh"
module tb_uhfp_host_regs;
  logic sys_clk = 1'b0, rst_n = 1'b0, hc_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic run_stop_bit = 1'b0, port_power_control = 1'b1, plug = 1'b0, wake = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [3:0] reg_be = 4'h0, port_test_select;
  logic [1:0] list_size_field = 2'h0, line_state_in;
  logic [13:0] sof_frame_number;
  logic [9:0] list_entry;
  logic reg_rvalid, connect_present_in, connect_event, port_reset_in, resume_detect;
  logic schedule_active, uframe_end, default_routing, port_owner_bit, port_power_bit;
  logic port_enabled_bit, port_suspend_bit, force_resume_bit;
  logic [31:0] idx [4] = '{32'h0000_0357, 32'h0000_0157, 32'h0000_0057, 32'h0000_0357};
  int fail_count = 0, comparisons = 0, cycles = 0, n = 0;
  always #50 sys_clk = ~sys_clk;
  uhfp_host_regs i_dut (.sys_clk, .rst_n, .hc_reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_be, .reg_rdata, .reg_rvalid, .run_stop_bit, .list_size_field, .port_power_control,
    .connect_present_in, .connect_event, .line_state_in, .port_reset_in, .resume_detect,
    .sof_frame_number, .list_entry, .schedule_active, .uframe_end, .default_routing,
    .port_owner_bit, .port_power_bit, .port_enabled_bit, .port_suspend_bit, .force_resume_bit,
    .port_test_select);
  uhfp_usb_device i_dev (.sys_clk, .plug, .wake, .connect_present_in, .connect_event,
    .line_state_in, .port_reset_in, .resume_detect);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= be;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h0000_0001);
    chk(reg_rdata, exp);
  endtask
  // counts edges up to the next microframe end, giving up after 1400 edges
  task automatic tick_wait();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (uframe_end !== 1'b1 && n < 1400);
  endtask
  task automatic t_reset();
    rdc(`UHFP_ADDR_PORT_SC, 32'h0000_2000);
    rdc(`UHFP_ADDR_FRAME_INDEX, 32'h0000_0000);
    rdc(8'h30, 32'h0000_0000);
  endtask
  task automatic t_config();
    wr(`UHFP_ADDR_CONFIG_FLAG, 32'h0000_0001, 4'h1);
    rdc(`UHFP_ADDR_PORT_SC, 32'h0000_0000);
    chk({31'h0, default_routing}, 32'h0000_0001);
    wr(`UHFP_ADDR_CONFIG_FLAG, 32'h0000_0000, 4'h1);
    rdc(`UHFP_ADDR_PORT_SC, 32'h0000_2000);
  endtask
  task automatic t_port();
    @(posedge sys_clk);
    plug <= 1'b1;
    rdc(`UHFP_ADDR_PORT_SC, 32'h0000_2800);
    wr(`UHFP_ADDR_PORT_SC, 32'h0000_2004, 4'hf);
    wr(`UHFP_ADDR_PORT_SC, 32'h0000_3000, 4'hf);
    rdc(`UHFP_ADDR_PORT_SC, 32'h0000_3803);
    wr(`UHFP_ADDR_PORT_SC, 32'h0001_3086, 4'hf);
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    rdc(`UHFP_ADDR_PORT_SC, 32'h0001_38c5);
    chk({28'h0, port_test_select}, 32'h0000_0001);
    chk({27'h0, port_owner_bit, port_power_bit, port_enabled_bit, port_suspend_bit,
      force_resume_bit}, 32'h0000_001f);
    @(posedge sys_clk);
    hc_reset <= 1'b1;
    @(posedge sys_clk);
    hc_reset <= 1'b0;
    rdc(`UHFP_ADDR_PORT_SC, 32'h0000_2800);
  endtask
  task automatic t_frame();
    wr(`UHFP_ADDR_FRAME_INDEX, 32'h0000_1ab8, 4'hf);
    wr(`UHFP_ADDR_FRAME_INDEX, 32'h0000_0000, 4'h3);
    rdc(`UHFP_ADDR_FRAME_INDEX, 32'h0000_1ab8);
    chk({18'h0, sof_frame_number}, 32'h0000_1ab8);
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      list_size_field <= c[1:0];
      repeat (2) @(posedge sys_clk);
      #1;
      chk({22'h0, list_entry}, idx[c]);
    end
    wr(`UHFP_ADDR_FRAME_INDEX, 32'h0000_3ffe, 4'hf);
    @(posedge sys_clk);
    run_stop_bit <= 1'b1;
    tick_wait();
    tick_wait();
    chk(n, 32'h0000_04e2);
    @(posedge sys_clk);
    #1;
    chk({18'h0, sof_frame_number}, 32'h0000_0000);
    chk({31'h0, schedule_active}, 32'h0000_0001);
    @(posedge sys_clk);
    run_stop_bit <= 1'b0;
    tick_wait();
    chk(n, 32'h0000_0578);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_config();
    t_port();
    t_frame();
    complete_run();
  end
  // cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      complete_run();
    end
  end
endmodule
bind uhfp_host_regs uhfp_host_regs_properties i_chk (.sys_clk, .rst_n, .hc_reset, .reg_wr,
  .reg_addr, .reg_wdata, .reg_be, .run_stop_bit, .list_size_field, .sof_frame_number,
  .list_entry, .uframe_end, .default_routing, .port_owner_bit, .port_power_bit,
  .port_enabled_bit, .port_suspend_bit, .force_resume_bit);
